// *** common/sar_params.svh ***
// constants for the successive-approximation conversion control block
// Summary of operation
// - start input falling edge ends acquisition, holds input, begins conversion
// - result found over 18 trial steps, most significant bit first
// - each trial weight is half the previous one, one weight per bit
// - after the last trial the code is formed, then busy goes low
// - busy rises at start and falls after the result is loaded, or without a load when reset input aborts
// - the result belongs to the sample just taken, no pipeline delay
// - three rate modes; fast mode sustains up to 800 kSPS
// - normal mode converts up to 666 kSPS with no idle limit
// - low-power mode saves power between conversions, up to 570 kSPS
// - low-power mode: start still low at acquisition end starts conversion
// - coding select chooses binary or twos complement except 18-bit parallel
// - output codes follow the ideal mapping, midscale 20000 or 00000
// - overrange input saturates at 3FFFF binary or 1FFFF twos complement
// - underrange input saturates at 00000 binary or 20000 twos complement
// - reset input high resets and aborts any conversion in progress
// - power-down lets the current conversion finish, then blocks conversions
`ifndef SAR_PARAMS_SVH
`define SAR_PARAMS_SVH
`define SAR_BITS 18
`define CLK_NS 50
`define FAST_KSPS 800
`define NORMAL_KSPS 666
`define LOWPWR_KSPS 570
`define PER_CYC(k) ((1000000 + (k) * `CLK_NS - 1) / ((k) * `CLK_NS))
`define CONV_CYC (`SAR_BITS + 2)
`define IDLE_US 1000
`define IDLE_CYC (`IDLE_US * 1000 / `CLK_NS)
`define OFF_CTRL 8'h00
`define OFF_STAT 8'h04
`define OFF_RESULT 8'h08
`define OFF_IRQ_STAT 8'h0c
`define OFF_IRQ_MASK 8'h10
`define CTRL_MODE_LSB 0
`define CTRL_BUSW_LSB 2
`define CTRL_RST 4'h1
`define IRQ_DONE 0
`define IRQ_REFUSED 1
`define IRQ_ABORT 2
`define IRQ_MASK_RST 3'h0
`endif

// *** common/sar_pkg.sv ***
// types shared by the conversion control block
`include "sar_params.svh"
package sar_pkg;
	typedef enum logic [2:0] {
		ST_ACQ = 3'b001,
		ST_CONV = 3'b010,
		ST_LOAD = 3'b100
	} conv_state_t;
	typedef enum logic [1:0] {
		MODE_FAST = 2'h0,
		MODE_NORMAL = 2'h1,
		MODE_LOWPWR = 2'h2
	} rate_mode_t;
	typedef enum logic [1:0] {
		BUSW_PAR18 = 2'h0,
		BUSW_PAR16 = 2'h1,
		BUSW_PAR8 = 2'h2,
		BUSW_SERIAL = 2'h3
	} bus_width_t;
	// least cycles from one start to the next for a rate mode
	function automatic logic [7:0] period_cyc(input logic [1:0] m);
		case (m)
			MODE_FAST: period_cyc = 8'(`PER_CYC(`FAST_KSPS));
			MODE_LOWPWR: period_cyc = 8'(`PER_CYC(`LOWPWR_KSPS));
			default: period_cyc = 8'(`PER_CYC(`NORMAL_KSPS));
		endcase
	endfunction : period_cyc
endpackage : sar_pkg

// *** hw/sar_trial_engine.sv ***
// successive-approximation trial sequencer, one trial per clock
`timescale 1ns/1ps
`default_nettype none
`include "sar_params.svh"
module sar_trial_engine import sar_pkg::*; #(
	parameter int BITS = `SAR_BITS
) (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic go,
	input wire logic abort,
	input wire logic comparator_high,
	output logic [BITS-1:0] trial_code,
	output logic done,
	output logic [BITS-1:0] code
);
	// elaboration check on the width
	if (BITS < 2 || BITS > 24) begin : g_bits_chk
		$error("sar_trial_engine: BITS out of range");
	end
	logic active_q;
	logic [BITS-1:0] weight_q;
	logic [BITS-1:0] trial_q;
	logic [BITS-1:0] code_q;
	logic done_q;
	wire [BITS-1:0] top_w = {1'b1, {(BITS-1){1'b0}}};
	// keep the trial bit when the held input is at or above the trial level
	wire [BITS-1:0] kept = comparator_high ? trial_q : (trial_q & ~weight_q);
	wire last = weight_q[0];
	// weights halve each step, MSB first, down to one LSB
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			active_q <= 1'b0;
			weight_q <= '0;
			trial_q <= '0;
			code_q <= '0;
			done_q <= 1'b0;
		end else if (abort) begin
			active_q <= 1'b0;
			weight_q <= '0;
			trial_q <= '0;
			done_q <= 1'b0;
		end else if (go) begin
			active_q <= 1'b1;
			weight_q <= top_w;
			trial_q <= top_w;
			done_q <= 1'b0;
		end else if (active_q) begin
			weight_q <= weight_q >> 1;
			trial_q <= last ? '0 : (kept | (weight_q >> 1));
			active_q <= !last;
			done_q <= last;
			if (last) begin
				code_q <= kept;
			end
		end else begin
			done_q <= 1'b0;
		end
	end
	assign trial_code = trial_q;
	assign done = done_q;
	assign code = code_q;
	property p_weight_halves;
		@(posedge clk) disable iff (!arst_n || abort)
		(active_q && !weight_q[0] && !go) |=> (weight_q == ($past(weight_q) >> 1));
	endproperty
	a_weight_halves: assert property (p_weight_halves) else $error("trial weight did not halve");
	property p_trial_count;
		@(posedge clk) disable iff (!arst_n || abort)
		go |-> ##1 (!done_q)[*8] ##11 done_q ##1 !done_q;
	endproperty
	a_trial_count: assert property (p_trial_count) else $error("trial count is not 18");
endmodule : sar_trial_engine
`default_nettype wire

// *** hw/sar_code_format.sv ***
// output code register with straight binary or twos complement coding
`timescale 1ns/1ps
`default_nettype none
`include "sar_params.svh"
module sar_code_format import sar_pkg::*; #(
	parameter int BITS = `SAR_BITS
) (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic load,
	input wire logic twos,
	input wire logic [BITS-1:0] raw,
	output logic [BITS-1:0] code
);
	logic [BITS-1:0] code_q;
	// twos complement flips only the top bit; clamped codes follow from it
	wire [BITS-1:0] fmt = twos ? {~raw[BITS-1], raw[BITS-2:0]} : raw;
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) code_q <= '0;
		else if (load) code_q <= fmt;
	end
	assign code = code_q;
	property p_twos_map;
		@(posedge clk) disable iff (!arst_n)
		(load && twos) |=> code_q == {~$past(raw[BITS-1]), $past(raw[BITS-2:0])};
	endproperty
	a_twos_map: assert property (p_twos_map) else $error("twos complement code wrong");
	property p_clamp;
		@(posedge clk) disable iff (!arst_n)
		(load && (&raw)) |=> code_q == ($past(twos) ? {1'b0, {(BITS-1){1'b1}}} : {BITS{1'b1}});
	endproperty
	a_clamp: assert property (p_clamp) else $error("overrange code wrong");
	property p_floor;
		@(posedge clk) disable iff (!arst_n)
		(load && !(|raw)) |=> code_q == ($past(twos) ? {1'b1, {(BITS-1){1'b0}}} : {BITS{1'b0}});
	endproperty
	a_floor: assert property (p_floor) else $error("underrange code wrong");
endmodule : sar_code_format
`default_nettype wire

// *** hw/sar_conversion_control.sv ***
// conversion control of the successive-approximation converter, AHB-Lite slave
`timescale 1ns/1ps
`default_nettype none
`include "sar_params.svh"
module sar_conversion_control import sar_pkg::*; #(
	parameter int BITS = `SAR_BITS,
	parameter logic [15:0] IDLE_LIMIT = 16'(`IDLE_CYC)
) (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic conversion_start_n,
	input wire logic coding_select,
	input wire logic power_down_input,
	input wire logic reset_input,
	input wire logic comparator_high,
	output logic [BITS-1:0] trial_code,
	output logic sample_hold,
	output logic busy,
	output logic power_save,
	output logic [BITS-1:0] result_code,
	output logic irq
);
	// elaboration checks on the parameters
	if (BITS != `SAR_BITS) begin : g_bits_chk
		$error("sar_conversion_control: BITS must be 18");
	end
	if (IDLE_LIMIT == 16'hffff) begin : g_idle_chk
		$error("sar_conversion_control: IDLE_LIMIT too large");
	end
	if (`PER_CYC(`FAST_KSPS) <= `CONV_CYC) begin : g_rate_chk
		$error("fast period shorter than conversion");
	end

	// pins: {reset, power-down, coding, start}
	logic [3:0] sync1_q;
	logic [3:0] sync2_q;
	logic start_prev_q;
	conv_state_t state_q;
	conv_state_t state_d;
	logic [15:0] since_q;
	logic [15:0] gap_q;
	logic busy_q;
	logic hold_q;
	logic save_q;
	logic first_q;
	logic [3:0] ctrl_q;
	logic [2:0] irq_stat_q;
	logic [2:0] irq_mask_q;
	logic dwr_q;
	logic [7:0] daddr_q;
	logic [31:0] rdata_q;
	logic eng_done;
	logic [BITS-1:0] eng_code;

	// two-stage synchroniser for the asynchronous pins
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			sync1_q <= 4'h1;
			sync2_q <= 4'h1;
			start_prev_q <= 1'b1;
		end else begin
			sync1_q <= {reset_input, power_down_input, coding_select, conversion_start_n};
			sync2_q <= sync1_q;
			start_prev_q <= sync2_q[0];
		end
	end

	// synchronised pin levels and the start edge
	wire start_n_s = sync2_q[0];
	wire coding_s = sync2_q[1];
	wire pwr_dn_s = sync2_q[2];
	wire rst_s = sync2_q[3];
	wire start_fall = start_prev_q && !start_n_s;

	// control fields and the least start spacing of the chosen mode
	wire [1:0] mode = ctrl_q[`CTRL_MODE_LSB +: 2];
	wire [1:0] busw = ctrl_q[`CTRL_BUSW_LSB +: 2];
	wire [15:0] per = {8'h00, period_cyc(mode)};
	wire acq_done = since_q >= per;
	wire ready = (state_q == ST_ACQ) && acq_done && !pwr_dn_s && !rst_s;
	wire held = (mode == MODE_LOWPWR) && !start_n_s && (since_q == per);
	wire accept = ready && (start_fall || held);
	wire refused = start_fall && !accept;
	wire abort_ev = rst_s && (state_q != ST_ACQ);
	wire twos_sel = !coding_s && (busw != BUSW_PAR18);

	// conversion sequencing: acquire, convert, load result
	always_comb begin
		state_d = state_q;
		case (state_q)
			ST_ACQ: begin
				if (accept) state_d = ST_CONV;
			end
			ST_CONV: begin
				if (eng_done) state_d = ST_LOAD;
			end
			ST_LOAD: begin
				state_d = ST_ACQ;
			end
			default: begin
				state_d = ST_ACQ;
			end
		endcase
		if (rst_s) state_d = ST_ACQ;
	end

	// state, busy, hold and power-saving outputs
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			state_q <= ST_ACQ;
			busy_q <= 1'b0;
			hold_q <= 1'b0;
			save_q <= 1'b0;
		end else begin
			state_q <= state_d;
			busy_q <= state_d != ST_ACQ;
			hold_q <= state_d == ST_CONV;
			save_q <= (state_d == ST_ACQ) && ((mode == MODE_LOWPWR) || pwr_dn_s);
		end
	end

	// cycles since the last accepted start, saturating
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			since_q <= 16'hffff;
			first_q <= 1'b0;
		end else if (accept) begin
			since_q <= 16'h0000;
			first_q <= (mode == MODE_FAST) && (since_q > IDLE_LIMIT);
		end else if (since_q != 16'hffff) begin
			since_q <= since_q + 16'h0001;
		end
	end

	// trial sequencer
	sar_trial_engine #(.BITS(BITS)) u_engine (
		.clk(clk),
		.arst_n(arst_n),
		.go(accept),
		.abort(rst_s),
		.comparator_high(comparator_high),
		.trial_code(trial_code),
		.done(eng_done),
		.code(eng_code)
	);

	// output code register, loaded before busy falls
	sar_code_format #(.BITS(BITS)) u_format (
		.clk(clk),
		.arst_n(arst_n),
		.load(eng_done),
		.twos(twos_sel),
		.raw(eng_code),
		.code(result_code)
	);

	// bus address phase decode
	wire ap = hsel && htrans[1] && hready;
	wire wr_ctrl = dwr_q && (daddr_q == `OFF_CTRL);
	wire wr_irqs = dwr_q && (daddr_q == `OFF_IRQ_STAT);
	wire wr_irqm = dwr_q && (daddr_q == `OFF_IRQ_MASK);
	wire [2:0] irq_ev = {abort_ev, refused, eng_done};
	wire [2:0] irq_clr = wr_irqs ? hwdata[2:0] : 3'h0;
	wire [31:0] stat_w = {24'h0, save_q, first_q, pwr_dn_s, state_q, hold_q, busy_q};
	wire [7:0] raddr = haddr[7:0];
	wire [31:0] rd_mux =
		(raddr == `OFF_CTRL) ? {28'h0, ctrl_q} :
		(raddr == `OFF_STAT) ? stat_w :
		(raddr == `OFF_RESULT) ? {14'h0, result_code} :
		(raddr == `OFF_IRQ_STAT) ? {29'h0, irq_stat_q} :
		(raddr == `OFF_IRQ_MASK) ? {29'h0, irq_mask_q} : 32'h0;

	// bus data phase capture and read data
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			dwr_q <= 1'b0;
			daddr_q <= 8'h00;
			rdata_q <= 32'h0;
		end else begin
			dwr_q <= ap && hwrite;
			daddr_q <= ap ? raddr : daddr_q;
			rdata_q <= (ap && !hwrite) ? rd_mux : 32'h0;
		end
	end

	// software registers; a new event wins over a same-cycle clear
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			ctrl_q <= `CTRL_RST;
			irq_stat_q <= 3'h0;
			irq_mask_q <= `IRQ_MASK_RST;
		end else begin
			ctrl_q <= wr_ctrl ? hwdata[3:0] : ctrl_q;
			irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_ev;
			irq_mask_q <= wr_irqm ? hwdata[2:0] : irq_mask_q;
		end
	end

	// outputs
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = rdata_q;
	assign busy = busy_q;
	assign sample_hold = hold_q;
	assign power_save = save_q;
	assign irq = |(irq_stat_q & irq_mask_q);

	// helper: cycles between accepted starts
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) gap_q <= 16'hffff;
		else if (accept) gap_q <= 16'h0001;
		else if (gap_q != 16'hffff) gap_q <= gap_q + 16'h0001;
	end

	property p_busy_window;
		@(posedge clk) disable iff (!arst_n || rst_s)
		accept |-> ##1 busy_q[*8] ##12 busy_q ##1 !busy_q;
	endproperty
	a_busy_window: assert property (p_busy_window) else $error("busy window not 20 cycles");

	property p_loaded_before_release;
		@(posedge clk) disable iff (!arst_n || rst_s)
		$fell(busy_q) |-> $past(eng_done, 2) && (result_code == $past(result_code));
	endproperty
	a_loaded_before_release: assert property (p_loaded_before_release) else $error("busy fell early");

	property p_start_spacing;
		@(posedge clk) disable iff (!arst_n)
		accept |-> (gap_q >= {8'h00, period_cyc(mode)});
	endproperty
	a_start_spacing: assert property (p_start_spacing) else $error("start faster than mode rate");

	property p_blocked_stays;
		@(posedge clk) disable iff (!arst_n)
		(state_q == ST_ACQ && pwr_dn_s) |=> (state_q == ST_ACQ);
	endproperty
	a_blocked_stays: assert property (p_blocked_stays) else $error("conversion while powered down");

	property p_down_finishes;
		@(posedge clk) disable iff (!arst_n || rst_s)
		(state_q == ST_CONV && pwr_dn_s) |-> ##[1:20] (state_q == ST_LOAD);
	endproperty
	a_down_finishes: assert property (p_down_finishes) else $error("power-down cut conversion");

	property p_reset_abort;
		@(posedge clk) disable iff (!arst_n)
		rst_s |=> (state_q == ST_ACQ) && !busy_q && !hold_q;
	endproperty
	a_reset_abort: assert property (p_reset_abort) else $error("reset did not abort");

	property p_held_start;
		@(posedge clk) disable iff (!arst_n)
		(state_q == ST_ACQ && mode == MODE_LOWPWR && since_q == per && !start_n_s
			&& !pwr_dn_s && !rst_s) |=> (state_q == ST_CONV);
	endproperty
	a_held_start: assert property (p_held_start) else $error("held start not taken");

	property p_fall_starts;
		@(posedge clk) disable iff (!arst_n)
		(start_fall && ready) |=> hold_q && busy_q;
	endproperty
	a_fall_starts: assert property (p_fall_starts) else $error("falling start ignored");

	property p_idle_flag;
		@(posedge clk) disable iff (!arst_n)
		(accept && mode == MODE_FAST && since_q > IDLE_LIMIT) |=> first_q;
	endproperty
	a_idle_flag: assert property (p_idle_flag) else $error("idle flag not raised");
endmodule : sar_conversion_control
`default_nettype wire

// *** tb/sar_analog_model.sv ***
// analog front end model: track and hold plus comparator against the trial word
`timescale 1ns/1ps
`default_nettype none
module sar_analog_model (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic signed [19:0] level,
	input wire logic sample_hold,
	input wire logic [17:0] trial_code,
	output logic comparator_high
);
	logic signed [19:0] held_q;
	// follow the input while acquiring, freeze it while trials run
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			held_q <= '0;
		end else if (!sample_hold) begin
			held_q <= level;
		end
	end
	// levels beyond either full scale pin every decision the same way
	assign comparator_high = held_q >= $signed({2'b00, trial_code});
endmodule : sar_analog_model
`default_nettype wire

// *** tb/sar_conversion_control_test.sv ***
// self-checking bench for the conversion control block
`timescale 1ns/1ps
`default_nettype none
`include "sar_params.svh"
module sar_conversion_control_test import sar_pkg::*; ;
	logic clk, arst_n, hsel, hwrite, start_n, cs, pwr_dn, rst_in, mask_on;
	logic [31:0] haddr, hwdata, hrdata, rv;
	logic [1:0] htrans;
	logic hreadyout, hresp, sh, busy, psave, irq, cmp;
	logic [17:0] trial, res;
	logic signed [19:0] level;
	logic signed [19:0] lv_tab [6] = '{20'sh20000, 20'sh20001, 20'sh1ffff, 20'sh3fffe,
		20'sh50000, -20'sd5};
	int err_total, n_checks, n, k;
	// block under test, idle limit shortened for simulation
	sar_conversion_control #(.IDLE_LIMIT(16'h0064)) i_sar_conversion_control (.clk(clk),
		.arst_n(arst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
		.hresp(hresp), .hrdata(hrdata), .conversion_start_n(start_n), .coding_select(cs),
		.power_down_input(pwr_dn), .reset_input(rst_in), .comparator_high(cmp),
		.trial_code(trial), .sample_hold(sh), .busy(busy), .power_save(psave),
		.result_code(res), .irq(irq));
	sar_analog_model i_sar_analog_model (.clk(clk), .arst_n(arst_n), .level(level),
		.sample_hold(sh), .trial_code(trial), .comparator_high(cmp));
	// 20 MHz clock
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] want);
		n_checks++;
		if (seen !== want) begin
			err_total++;
			$display("unexpected at %0t: saw %h, expected %h", $time, seen, want);
		end
	endtask : chk
	task automatic wrap_up();
		$display("checks %0d, mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : wrap_up
	// one single-word transfer: address phase, then data phase
	task automatic bus(input logic [31:0] a, input logic w, input logic [31:0] wd);
		@(posedge clk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= w;
		do @(posedge clk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge clk); while (hreadyout !== 1'b1);
		rv = hrdata;
	endtask : bus
	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		bus(a, 1'b1, d);
	endtask : wr
	task automatic rc(input logic [31:0] a, input logic [31:0] want);
		bus(a, 1'b0, 32'h0);
		chk(rv, want);
		chk({31'h0, hresp}, 32'h0);
	endtask : rc
	// start, watch busy; act 1 start low, 2 power down, 3 reset, all mid conversion
	task automatic conv(input logic signed [19:0] lv, input int act, output int nb);
		int t;
		@(posedge clk);
		start_n <= 1'b1;
		level <= lv;
		repeat (40) @(posedge clk);
		start_n <= 1'b0;
		t = 0;
		do begin
			@(negedge clk);
			t++;
		end while (busy !== 1'b1 && t < 10);
		if (busy === 1'b1) chk({14'h0, trial}, 32'h20000);
		if (busy === 1'b1) chk({31'h0, sh}, 32'h1);
		nb = 0;
		while (busy === 1'b1 && nb < 40) begin
			nb++;
			@(posedge clk);
			if (nb == 1) start_n <= 1'b1;
			if (nb == 1) level <= ~lv;
			if (nb == 8) begin
				start_n <= (act != 1);
				pwr_dn <= (act == 2);
				rst_in <= (act == 3);
			end
			@(negedge clk);
		end
	endtask : conv
	task automatic conv_ok(input logic signed [19:0] lv, input logic tw);
		int nb;
		logic [17:0] c;
		c = (lv < 0) ? 18'h0 : (lv > 20'sh3ffff) ? 18'h3ffff : lv[17:0];
		c[17] = c[17] ^ tw;
		conv(lv, 0, nb);
		chk(nb, 20);
		chk({31'h0, sh}, 32'h0);
		chk({14'h0, res}, {14'h0, c});
		rc(`OFF_RESULT, {14'h0, c});
		rc(`OFF_IRQ_STAT, 32'h1);
		chk({31'h0, irq}, {31'h0, mask_on});
		wr(`OFF_IRQ_STAT, 32'h7);
		@(negedge clk);
		chk({31'h0, irq}, 32'h0);
	endtask : conv_ok
	// hang guard
	initial begin
		repeat (20000) @(posedge clk);
		err_total++;
		wrap_up();
	end
	// main sequence
	initial begin
		arst_n = 1'b0;
		hsel = 1'b0;
		haddr = '0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hwdata = '0;
		start_n = 1'b1;
		cs = 1'b1;
		pwr_dn = 1'b0;
		rst_in = 1'b0;
		level = '0;
		mask_on = 1'b0;
		repeat (10) @(posedge clk);
		arst_n <= 1'b1;
		rc(`OFF_CTRL, 32'h1);
		rc(`OFF_IRQ_MASK, 32'h0);
		rc(`OFF_STAT, 32'h4);
		rc(32'h40, 32'h0);
		wr(`OFF_RESULT, 32'h15);
		rc(`OFF_RESULT, 32'h0);
		wr(`OFF_CTRL, 32'h5);
		foreach (lv_tab[i]) for (int t = 0; t < 2; t++) begin
			@(posedge clk);
			cs <= t[0];
			conv_ok(lv_tab[i], !t[0]);
			if (i == 0 && t == 0) mask_on = 1'b1;
			if (i == 0 && t == 0) wr(`OFF_IRQ_MASK, 32'h7);
		end
		wr(`OFF_CTRL, 32'h1);
		cs <= 1'b0;
		conv_ok(20'sh20001, 1'b0);
		wr(`OFF_CTRL, 32'h4);
		repeat (120) @(posedge clk);
		for (int j = 0; j < 2; j++) begin
			conv_ok(20'sh100, 1'b1);
			bus(`OFF_STAT, 1'b0, 32'h0);
			chk({31'h0, rv[6]}, {31'h0, j == 0});
		end
		for (int m = 0; m < 3; m++) begin
			wr(`OFF_CTRL, 32'h4 | m);
			conv(20'sh200, 1, n);
			chk(n, 20);
			k = 0;
			repeat (30) begin
				@(negedge clk);
				if (busy === 1'b1) k = 1;
			end
			chk(k, m == 2);
			while (busy === 1'b1) @(negedge clk);
			rc(`OFF_IRQ_STAT, 32'h3);
			chk({31'h0, psave}, {31'h0, m == 2});
			wr(`OFF_IRQ_STAT, 32'h7);
		end
		wr(`OFF_CTRL, 32'h5);
		conv(20'sh300, 2, n);
		chk(n, 20);
		conv(20'sh300, 0, n);
		chk(n, 0);
		chk({31'h0, psave}, 32'h1);
		rc(`OFF_IRQ_STAT, 32'h3);
		wr(`OFF_IRQ_STAT, 32'h7);
		pwr_dn <= 1'b0;
		conv(20'sh300, 3, n);
		chk({31'h0, n < 20}, 32'h1);
		@(posedge clk);
		rst_in <= 1'b0;
		rc(`OFF_IRQ_STAT, 32'h4);
		wr(`OFF_IRQ_STAT, 32'h7);
		wr(`OFF_CTRL, 32'h5);
		conv_ok(20'sh1ffff, 1'b1);
		wrap_up();
	end
endmodule : sar_conversion_control_test
`default_nettype wire
